// *** rtl/gvc_core.sv ***
// guest virtualization control: guest flag, levels and hypervisor status register
//
// Behaviour
// - guest flag picks guest or host levels
// - two-stage translation active exactly when guest
// - host sup above guest sup above guest user
// - nominal privilege user or supervisor reported
// - guest flag redirects supervisor CSRs to replicas
// - direct replica access under guest traps
// - replicas direct only from machine/host sup
// - inactive copies hold values, steer nothing
// - unreplicated supervisor CSRs keep normal function
// - guest width field WARL, host-64 only
// - host widening sets widest guest width
// - guest-return trap bit traps sup return
// - guest-wait trap bit traps late wait
// - guest-translation bit traps fences, root CSR
// - interrupt select zero to count inclusive
// - user hypervisor access bit gates user hypervisor load/stores
// - previous guest flag captured, restored on return
// - previous guest level captured from guest only
// - guest address flag written on every trap
// - guest endianness bit, little when zero
`include "gvc_map.svh"
module gvc_core
    import gvc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire gvc_level_t enter_level,
    input wire logic enter_valid,
    input wire logic host_is_64,
    input wire logic mach_wait_trap,
    input wire logic wait_done,
    input wire gvc_instr_t instr,
    input wire gvc_trap_t trap,
    output gvc_level_t level,
    output logic guest_flag,
    output logic two_stage_on,
    output logic nominal_sup,
    output logic guest_sup_irq_off,
    output logic sel_replica,
    output gvc_exc_t exc,
    output logic [63:0] csr_rdata,
    output logic [5:0] guest_ext_irq_select,
    output logic guest_big_endian,
    output logic guest_lvl_sup
);
    // ****************************************
    // decode helpers
    // ****************************************
    // replica CSRs sit in the 0x2xx block; translation root at 0x180
    function automatic logic is_replica(input logic [11:0] a);
        is_replica = (a[11:8] == `GVC_CSR_REPLICA_BLK);
    endfunction : is_replica

    function automatic logic is_guest(input gvc_level_t l);
        is_guest = (l == GVC_LVL_GSUP) || (l == GVC_LVL_GUSR);
    endfunction : is_guest

    function automatic logic is_user_lvl(input gvc_level_t l);
        is_user_lvl = (l == GVC_LVL_USER) || (l == GVC_LVL_GUSR);
    endfunction : is_user_lvl

    localparam logic [11:0] STATUS_ADDR = `GVC_CSR_STATUS;
    localparam logic [11:0] ROOT_ADDR = `GVC_CSR_ROOT;
    localparam int WAIT_CYC = `GVC_WFI_LIMIT_CYC;

    gvc_level_t level_q, level_d;
    logic [63:0] hst_q, hst_d;
    logic host64_q;
    logic [7:0] wait_cnt_q;
    gvc_exc_t exc_q, exc_d;
    logic [63:0] rdata_q;
    logic sel_q, off_q;
    logic nom_q;
    logic host64_sync1_q, host64_sync2_q;

    wire guest_now = is_guest(level_q);
    wire in_gsup = (level_q == GVC_LVL_GSUP);
    wire in_user = is_user_lvl(level_q);
    wire hi_priv = (level_q == GVC_LVL_MACH) || (level_q == GVC_LVL_HSUP);
    wire wr_status = instr.valid && instr.csr_acc && instr.csr_wr
        && (instr.csr_addr == STATUS_ADDR) && hi_priv;

    // ****************************************
    // exception verdict
    // ****************************************
    // direct replica access from guest: user gets illegal, sup gets virtual
    wire rep_direct = instr.valid && instr.csr_acc && is_replica(instr.csr_addr);
    wire rep_bad_user = rep_direct && in_user;
    wire rep_bad_guest = rep_direct && (level_q == GVC_LVL_GSUP);
    wire trap_guest_return_hit = instr.valid && instr.sup_return_op && in_gsup && hst_q[`GVC_HST_TRAP_GUEST_RETURN];
    wire trap_guest_translation_ops_hit = instr.valid && in_gsup && hst_q[`GVC_HST_TRAP_GUEST_TRANSLATION_OPS]
        && (instr.fence_vma || instr.inval_vma
        || (instr.csr_acc && instr.csr_addr == ROOT_ADDR));
    // wait held past a short bound traps, cheaper than waking logic
    wire vtw_hit = instr.valid && instr.wait_irq_op && in_gsup && hst_q[`GVC_HST_VTW]
        && !mach_wait_trap && !wait_done && (wait_cnt_q >= 8'(WAIT_CYC));
    wire hyp_user_bad = instr.valid && (level_q == GVC_LVL_USER)
        && (instr.hyp_other || (instr.hyp_ldst && !hst_q[`GVC_HST_HU]));
    wire hyp_guest_bad = instr.valid && guest_now && (instr.hyp_ldst || instr.hyp_other);
    // illegal outranks virtual, so user-level faults stay illegal
    assign exc_d.illegal = rep_bad_user || hyp_user_bad || (rep_direct && !hi_priv && !in_gsup);
    assign exc_d.virt_instr = !exc_d.illegal
        && (rep_bad_guest || trap_guest_return_hit || trap_guest_translation_ops_hit || vtw_hit || hyp_guest_bad);

    // ****************************************
    // status register next value
    // ****************************************
    logic [63:0] wmask;
    logic [5:0] guest_ext_irq_select_w;
    logic [1:0] guest_word_width_w;
    always_comb
    begin
        hst_d = hst_q;
        wmask = '0;
        wmask[`GVC_HST_TRAP_GUEST_RETURN] = 1'b1;
        wmask[`GVC_HST_VTW] = 1'b1;
        wmask[`GVC_HST_TRAP_GUEST_TRANSLATION_OPS] = 1'b1;
        wmask[`GVC_HST_HU] = 1'b1;
        wmask[`GVC_HST_PREV_GUEST_LEVEL] = 1'b1;
        wmask[`GVC_HST_SPV] = 1'b1;
        wmask[`GVC_HST_GVA] = 1'b1;
        wmask[`GVC_HST_GUEST_BIG_ENDIAN] = 1'b1;
        guest_ext_irq_select_w = instr.csr_wdata[`GVC_HST_GUEST_EXT_IRQ_SELECT_HI:`GVC_HST_GUEST_EXT_IRQ_SELECT_LO];
        guest_word_width_w = instr.csr_wdata[`GVC_HST_GUEST_WORD_WIDTH_HI:`GVC_HST_GUEST_WORD_WIDTH_LO];
        if (wr_status)
        begin
            hst_d = (hst_q & ~wmask) | (instr.csr_wdata & wmask);
            // out-of-range select keeps old value
            if (guest_ext_irq_select_w <= `GVC_GEIL_COUNT)
                hst_d[`GVC_HST_GUEST_EXT_IRQ_SELECT_HI:`GVC_HST_GUEST_EXT_IRQ_SELECT_LO] = guest_ext_irq_select_w;
            if (host64_q && (guest_word_width_w == `GVC_XL_32 || guest_word_width_w == `GVC_XL_64))
                hst_d[`GVC_HST_GUEST_WORD_WIDTH_HI:`GVC_HST_GUEST_WORD_WIDTH_LO] = guest_word_width_w;
        end
        // widening host: pick widest guest width that fits
        if (host64_sync2_q && !host64_q)
            hst_d[`GVC_HST_GUEST_WORD_WIDTH_HI:`GVC_HST_GUEST_WORD_WIDTH_LO] = `GVC_XL_64;
        if (trap.take)
        begin
            hst_d[`GVC_HST_SPV] = guest_now;
            // from host the level bit holds, even against a same-cycle write
            if (guest_now)
                hst_d[`GVC_HST_PREV_GUEST_LEVEL] = (level_q == GVC_LVL_GSUP);
            else
                hst_d[`GVC_HST_PREV_GUEST_LEVEL] = hst_q[`GVC_HST_PREV_GUEST_LEVEL];
            hst_d[`GVC_HST_GVA] = trap.guest_va;
        end
    end

    // ****************************************
    // level tracking
    // ****************************************
    always_comb
    begin
        level_d = level_q;
        if (trap.take)
            level_d = GVC_LVL_HSUP;
        else if (instr.valid && instr.sup_return_op && !guest_now && hi_priv && !exc_d.virt_instr)
            level_d = hst_q[`GVC_HST_SPV] ? GVC_LVL_GSUP : GVC_LVL_HSUP;
        else if (enter_valid)
            level_d = enter_level;
    end

    // read view: guest width hidden when host is 32
    wire [63:0] hst_view = host64_q ? hst_q
        : {32'h0000_0000, hst_q[31:0]};

    // ****************************************
    // registers
    // ****************************************
    // host width pin: two flops, only the second reads the first
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host64_sync1_q <= 1'b0;
            host64_sync2_q <= 1'b0;
        end
        else
        begin
            host64_sync1_q <= host_is_64;
            host64_sync2_q <= host64_sync1_q;
        end
    end

    // wait bound counter, restarts per wait
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wait_cnt_q <= 8'h00;
        else if (instr.valid && instr.wait_irq_op && !wait_done && wait_cnt_q != 8'hff)
            wait_cnt_q <= wait_cnt_q + 8'h01;
        else if (!(instr.valid && instr.wait_irq_op))
            wait_cnt_q <= 8'h00;
    end

    // state and answers, all one edge after the request
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            level_q <= GVC_LVL_MACH;
            nom_q <= 1'b1;
            hst_q <= `GVC_HST_RESET;
            host64_q <= 1'b0;
            exc_q <= '0;
            rdata_q <= '0;
            sel_q <= 1'b0;
            off_q <= 1'b0;
        end
        else
        begin
            level_q <= level_d;
            hst_q <= hst_d;
            host64_q <= host64_sync2_q;
            exc_q <= exc_d;
            rdata_q <= (instr.valid && instr.csr_acc && instr.csr_addr == STATUS_ADDR)
                ? hst_view : 64'h0000_0000_0000_0000;
            sel_q <= is_guest(level_d);
            off_q <= (level_d == GVC_LVL_USER);
            nom_q <= !is_user_lvl(level_d);
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign level = level_q;
    assign guest_flag = sel_q;
    assign two_stage_on = sel_q;
    assign nominal_sup = nom_q;
    assign guest_sup_irq_off = off_q;
    assign sel_replica = sel_q;
    assign exc = exc_q;
    assign csr_rdata = rdata_q;
    assign guest_ext_irq_select = hst_q[`GVC_HST_GUEST_EXT_IRQ_SELECT_HI:`GVC_HST_GUEST_EXT_IRQ_SELECT_LO];
    assign guest_big_endian = hst_q[`GVC_HST_GUEST_BIG_ENDIAN];
    assign guest_lvl_sup = hst_q[`GVC_HST_PREV_GUEST_LEVEL];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // trap entry, host return and narrow read, as separate steps
    sequence s_trap_from_guest;
        trap.take && guest_now;
    endsequence
    sequence s_host_return;
        instr.valid && instr.sup_return_op && !guest_now && hi_priv
            && hst_q[`GVC_HST_SPV] && !trap.take;
    endsequence
    sequence s_narrow_status_read;
        !host64_q && instr.valid && instr.csr_acc && instr.csr_addr == STATUS_ADDR;
    endsequence
    a_flag_tracks_level: assert property (guest_flag == is_guest(level_q))
        else $error("guest flag disagrees with level");
    a_two_stage_flag: assert property (two_stage_on == guest_flag)
        else $error("two-stage mismatch");
    a_spv_capture: assert property (s_trap_from_guest |=> hst_q[`GVC_HST_SPV])
        else $error("previous guest flag not captured");
    a_prev_guest_level_hold: assert property (trap.take && !guest_now
        |=> $stable(hst_q[`GVC_HST_PREV_GUEST_LEVEL]))
        else $error("previous guest level changed from host");
    a_gva_write: assert property (trap.take
        |=> hst_q[`GVC_HST_GVA] == $past(trap.guest_va))
        else $error("guest address flag wrong");
    a_trap_guest_return_trap: assert property (trap_guest_return_hit |=> exc.virt_instr)
        else $error("guest return not trapped");
    a_trap_guest_translation_ops_trap: assert property (trap_guest_translation_ops_hit |=> exc.virt_instr)
        else $error("translation op not trapped");
    a_user_hyp: assert property (hyp_user_bad |=> exc.illegal && !exc.virt_instr)
        else $error("user hypervisor op not illegal");
    a_replica_user: assert property (rep_bad_user |=> exc.illegal)
        else $error("user replica access not illegal");
    a_guest_ext_irq_select_range: assert property (guest_ext_irq_select <= `GVC_GEIL_COUNT)
        else $error("select out of range");
    a_user_irq_off: assert property (level_q == GVC_LVL_USER |-> guest_sup_irq_off)
        else $error("guest irq not off in user");
    // level capture, wait bound, width handling
    a_prev_guest_level_capture: assert property (s_trap_from_guest
        |=> hst_q[`GVC_HST_PREV_GUEST_LEVEL] == ($past(level_q) == GVC_LVL_GSUP))
        else $error("previous guest level not captured");
    a_vtw_trap: assert property (vtw_hit |=> exc.virt_instr)
        else $error("stalled guest wait not trapped");
    a_replica_guest: assert property (rep_bad_guest |=> exc.virt_instr && !exc.illegal)
        else $error("guest replica access not virtual");
    a_nominal_user: assert property (is_user_lvl(level_q) |-> !nominal_sup)
        else $error("user level reported as supervisor");
    a_trap_level: assert property (trap.take |=> level_q == GVC_LVL_HSUP && !guest_flag)
        else $error("trap did not land in host supervisor");
    a_return_guest: assert property (s_host_return
        |=> level_q == GVC_LVL_GSUP && guest_flag)
        else $error("return did not restore guest flag");
    a_width_widen: assert property (host64_sync2_q && !host64_q
        |=> hst_q[`GVC_HST_GUEST_WORD_WIDTH_HI:`GVC_HST_GUEST_WORD_WIDTH_LO] == `GVC_XL_64)
        else $error("widened host left narrow guest width");
    a_width_hidden: assert property (s_narrow_status_read
        |=> csr_rdata[63:32] == 32'h0000_0000)
        else $error("guest width visible on narrow host");
endmodule : gvc_core

// *** rtl/gvc_map.svh ***
// register layout, reset values and encodings for the guest virtualization control
`ifndef GVC_MAP_SVH
`define GVC_MAP_SVH
`define GVC_HST_GUEST_WORD_WIDTH_LO 32
`define GVC_HST_GUEST_WORD_WIDTH_HI 33
`define GVC_HST_TRAP_GUEST_RETURN 22
`define GVC_HST_VTW 21
`define GVC_HST_TRAP_GUEST_TRANSLATION_OPS 20
`define GVC_HST_GUEST_EXT_IRQ_SELECT_LO 12
`define GVC_HST_GUEST_EXT_IRQ_SELECT_HI 17
`define GVC_HST_HU 9
`define GVC_HST_PREV_GUEST_LEVEL 8
`define GVC_HST_SPV 7
`define GVC_HST_GVA 6
`define GVC_HST_GUEST_BIG_ENDIAN 5
`define GVC_XL_32 2'h1
`define GVC_XL_64 2'h2
`define GVC_HST_RESET 64'h0000_0002_0000_0000
`define GVC_CSR_STATUS 12'h600
`define GVC_CSR_ROOT 12'h180
`define GVC_CSR_REPLICA_BLK 4'h2
`define GVC_GEIL_COUNT 6'h07
`define GVC_WFI_LIMIT_NS 1000
`define GVC_WFI_LIMIT_CYC ((`GVC_WFI_LIMIT_NS * 20) / 1000)
`endif

// *** rtl/gvc_pkg.sv ***
// types shared by the guest virtualization control
package gvc_pkg;
    // operating level, gray coded along user/host sup/machine/guest sup/guest user
    typedef enum logic [2:0] {
        GVC_LVL_USER = 3'b000,
        GVC_LVL_HSUP = 3'b001,
        GVC_LVL_MACH = 3'b011,
        GVC_LVL_GSUP = 3'b010,
        GVC_LVL_GUSR = 3'b110
    } gvc_level_t;

    // one decoded instruction presented by the pipeline
    typedef struct packed {
        logic valid;
        logic csr_acc;
        logic [11:0] csr_addr;
        logic csr_wr;
        logic [63:0] csr_wdata;
        logic sup_return_op;
        logic wait_irq_op;
        logic fence_vma;
        logic inval_vma;
        logic hyp_ldst;
        logic hyp_other;
    } gvc_instr_t;

    // trap entry into host supervisor level
    typedef struct packed {
        logic take;
        logic guest_va;
    } gvc_trap_t;

    // verdict on the current instruction
    typedef struct packed {
        logic illegal;
        logic virt_instr;
    } gvc_exc_t;
endpackage : gvc_pkg

// *** test/tb_top.sv ***
// self-checking bench for the guest virtualization control
`include "gvc_map.svh"
module tb_top
    import gvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // stimulus and dut
    // ****************
    logic sys_clk = 0;
    logic sys_rst = 1;
    gvc_level_t enter_level = GVC_LVL_MACH;
    logic enter_valid = 0;
    logic host_is_64 = 1;
    logic mach_wait_trap = 0;
    logic wait_done = 0;
    gvc_instr_t instr = '0;
    gvc_trap_t trap = '0;
    gvc_level_t level;
    gvc_exc_t exc;
    logic guest_flag, two_stage_on, nominal_sup, guest_sup_irq_off, sel_replica;
    logic guest_big_endian, guest_lvl_sup;
    logic [63:0] csr_rdata;
    logic [5:0] guest_ext_irq_select;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [63:0] st;
    gvc_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .enter_level(enter_level),
        .enter_valid(enter_valid), .host_is_64(host_is_64), .mach_wait_trap(mach_wait_trap),
        .wait_done(wait_done), .instr(instr), .trap(trap), .level(level),
        .guest_flag(guest_flag), .two_stage_on(two_stage_on), .nominal_sup(nominal_sup),
        .guest_sup_irq_off(guest_sup_irq_off), .sel_replica(sel_replica), .exc(exc),
        .csr_rdata(csr_rdata), .guest_ext_irq_select(guest_ext_irq_select),
        .guest_big_endian(guest_big_endian), .guest_lvl_sup(guest_lvl_sup));
    // 50 ns period; hang guard well above the sequence length
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            end_of_test();
        end
    end
    // ****************
    // access tasks
    // ****************
    function automatic logic [63:0] bt(input int p);
        return 64'h0000_0000_0000_0001 << p;
    endfunction : bt
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one instruction for one cycle; registered answers sampled after the next edge
    task automatic issue(input gvc_instr_t i);
        @(posedge sys_clk) instr <= i;
        @(posedge sys_clk) instr <= '0;
        #1;
    endtask : issue
    task automatic csr(input logic [11:0] a, input logic w, input logic [63:0] d);
        gvc_instr_t i;
        i = '0;
        i.valid = 1;
        i.csr_acc = 1;
        i.csr_addr = a;
        i.csr_wr = w;
        i.csr_wdata = d;
        issue(i);
    endtask : csr
    task automatic op(input int k);
        gvc_instr_t i;
        i = '0;
        i.valid = 1;
        i.sup_return_op = (k == 0);
        i.wait_irq_op = (k == 1);
        i.fence_vma = (k == 2);
        i.inval_vma = (k == 3);
        i.hyp_ldst = (k == 4);
        issue(i);
    endtask : op
    task automatic go(input gvc_level_t l);
        @(posedge sys_clk) enter_level <= l;
        enter_valid <= 1;
        @(posedge sys_clk) enter_valid <= 0;
        #1;
    endtask : go
    task automatic take(input logic va);
        @(posedge sys_clk) trap <= '{1'b1, va};
        @(posedge sys_clk) trap <= '0;
        #1;
    endtask : take
    // hold a wait in place; n counts edges until the verdict flags it
    task automatic stall(input logic mwt, input logic done, output int n);
        gvc_instr_t i;
        i = '0;
        i.valid = 1;
        i.wait_irq_op = 1;
        @(posedge sys_clk) instr <= i;
        mach_wait_trap <= mwt;
        wait_done <= done;
        for (n = 0; n < 40 && exc.virt_instr !== 1'b1; n++)
            @(posedge sys_clk) #1;
        @(posedge sys_clk) instr <= '0;
        mach_wait_trap <= 0;
        wait_done <= 0;
        #1;
    endtask : stall
    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // ****************
    // main sequence
    // ****************
    initial
    begin
        int n;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 0;
        // host width pin crosses two flops and a holding register first
        repeat (4) @(posedge sys_clk);
        csr(12'h600, 0, 0);
        check(csr_rdata, `GVC_HST_RESET);
        check(guest_flag, 0);
        st = `GVC_HST_RESET | bt(`GVC_HST_TRAP_GUEST_RETURN) | bt(`GVC_HST_VTW) | bt(`GVC_HST_TRAP_GUEST_TRANSLATION_OPS)
            | (64'h7 << `GVC_HST_GUEST_EXT_IRQ_SELECT_LO) | bt(`GVC_HST_HU) | bt(`GVC_HST_SPV)
            | bt(`GVC_HST_GUEST_BIG_ENDIAN);
        csr(12'h600, 1, st);
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        check({guest_ext_irq_select, guest_big_endian}, {6'h07, 1'b1});
        // select beyond the source count must not land
        csr(12'h600, 1, (st & ~(64'h3f << 12)) | (64'h8 << 12));
        check(guest_ext_irq_select, 6'h07);
        // narrow guest, then widen host: width field follows
        st[33:32] = `GVC_XL_32;
        csr(12'h600, 1, st);
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        @(posedge sys_clk) host_is_64 <= 0;
        repeat (6) @(posedge sys_clk);
        // narrow host hides the guest width field
        csr(12'h600, 0, 0);
        check(csr_rdata, st & 64'h0000_0000_ffff_ffff);
        @(posedge sys_clk) host_is_64 <= 1;
        repeat (6) @(posedge sys_clk);
        st[33:32] = `GVC_XL_64;
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        go(GVC_LVL_HSUP);
        op(0);
        check({level, guest_flag, two_stage_on, sel_replica, nominal_sup},
            {GVC_LVL_GSUP, 4'hf});
        for (n = 0; n < 4; n++)
        begin
            op(n == 1 ? 0 : n);
            check({exc.illegal, exc.virt_instr}, 2'b01);
        end
        csr(12'h180, 0, 0);
        check({exc.illegal, exc.virt_instr}, 2'b01);
        csr(12'h240, 0, 0);
        check({exc.illegal, exc.virt_instr}, 2'b01);
        csr(12'h600, 1, 0);
        // a wait that the machine traps, or that completes, is left alone
        stall(1, 0, n);
        check(n, 40);
        stall(0, 1, n);
        check(n, 40);
        // stalled wait traps at the bound, one more edge for the verdict
        stall(0, 0, n);
        check(n, `GVC_WFI_LIMIT_CYC + 1);
        check(exc.virt_instr, 1);
        take(1);
        st = st | bt(`GVC_HST_PREV_GUEST_LEVEL) | bt(`GVC_HST_GVA);
        check({level, guest_flag, guest_lvl_sup}, {GVC_LVL_HSUP, 2'b01});
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        go(GVC_LVL_GUSR);
        check({guest_flag, nominal_sup}, 2'b10);
        csr(12'h240, 0, 0);
        check({exc.illegal, exc.virt_instr}, 2'b10);
        take(0);
        st = st & ~bt(`GVC_HST_PREV_GUEST_LEVEL) & ~bt(`GVC_HST_GVA);
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        go(GVC_LVL_USER);
        check(guest_sup_irq_off, 1);
        op(4);
        check({exc.illegal, exc.virt_instr}, 2'b00);
        csr(12'h600, 1, 64'hffff_ffff_ffff_ffff);
        take(0);
        st = st & ~bt(`GVC_HST_SPV);
        csr(12'h600, 0, 0);
        check(csr_rdata, st);
        st = st & ~bt(`GVC_HST_HU);
        csr(12'h600, 1, st);
        go(GVC_LVL_USER);
        op(4);
        check({exc.illegal, exc.virt_instr}, 2'b10);
        end_of_test();
    end
endmodule : tb_top
